/* rtl/dsd_datapath.sv */
// Purpose: Dual-channel sample datapath ahead of the converter cores.
// Assumes: Source presents a sample in every cycle its take strobe is high.
// Notes: Pipeline delay changes when half-band or inverse sinc stages are switched in or out.
`timescale 1ns/1ps
`default_nettype none
`include "dsd_cfg.svh"

// How it works
// R1 - Format bit 0 means twos complement input, 1 means offset binary.
// R2 - 16-bit offset binary: 0x0000 is negative, 0xFFFF positive full scale.
// R3 - 11-bit offset binary: 0xFFE0 is positive full scale, low five bits unused.
// R4 - Three cascadable half-band stages, each doubling the sample rate.
// R5 - Mode 0 bypass, 1 gives 2x, 3 gives 4x, 4 gives 8x.
// R6 - Status flag reads high while the mode field holds an unsupported code.
// R7 - Source supplies samples at DAC rate over interpolation factor, within limits.
// R8 - All settings kept per channel; writes go to the paged channels.
// R9 - Page 1 is channel 0, 2 is channel 1, 3 (reset) both.
// R10 - Seven-tap inverse sinc FIR, enable bit set after reset.
// R11 - Gain enabled after reset with gain value 0xAEA.
// R12 - Sample multiplied by 12-bit unsigned gain divided by 2048.
// R13 - Gain value built from low byte and four bits of next register.
// R14 - Software should program about 3.3 dB for 4x and 3.5 dB for 8x.
// R15 - Keep gain enabled with blanking, else hold transmit permit high.
// R16 - DC offset added only while its enable bit is set.
// R17 - Offset is 16-bit whole LSBs plus 5-bit signed sixteenths.
// R18 - Whole offset low and high bytes come from consecutive registers.
// R19 - Sixteenths taken from low five bits, range -16 to 15.
// R20 - Gain applied per channel independently for I/Q balance.
// R21 - Order: format, interpolation, inverse sinc, gain, offset; bypass is exact.
// R22 - Gain and offset results saturate instead of wrapping.
module dsd_datapath import dsd_pkg::*; #(
    parameter int RES_BITS = `DSD_RES_BITS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Sample inputs
    input wire dsd_sample_t ch0_sample,
    input wire dsd_sample_t ch1_sample,
    output logic ch0_take,
    output logic ch1_take,
    // Converter codes
    output dsd_sample_t dac0_code,
    output dsd_sample_t dac1_code
);

    // Unused low bits of a narrower converter are forced to zero in the input sample
    localparam logic [15:0] RES_MASK = 16'(16'hFFFF << (16 - RES_BITS));

    function automatic logic wr_to(input logic [11:0] target);
        return reg_wr && (reg_addr == target);
    endfunction

    logic [1:0] page;
    wire dsd_sample_t in_s [2];
    wire logic [1:0] take;
    wire logic [7:0] rb [2];
    wire logic rd_ch;
    wire logic [7:0] rd_byte;

    assign in_s[0] = ch0_sample;
    assign in_s[1] = ch1_sample;
    assign ch0_take = take[0];
    assign ch1_take = take[1];

    // ************************************************************
    // Page select
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            page <= `DSD_R_PAGE; // see R9
        end else if (wr_to(`DSD_A_PAGE)) begin
            page <= reg_wdata[1:0];
        end
    end

    // Reads follow the lowest paged channel
    assign rd_ch = ~page[0] & page[1]; // see R9
    assign rd_byte = (reg_addr == `DSD_A_PAGE) ? {6'h00, page} : rb[rd_ch];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_byte;
        end
    end

    // ************************************************************
    // Per-channel settings and datapath
    // ************************************************************
    for (genvar c = 0; c < 2; c++) begin : ch_g
        logic fmt_sel;
        logic rolloff_comp_on;
        logic scaling_on;
        logic [2:0] interp_ratio_field;
        logic bias_add_on;
        logic [7:0] off_lo;
        logic [7:0] off_hi;
        logic [4:0] fractional_bias;
        logic [7:0] scal_lo;
        logic [3:0] scal_hi;
        logic [2:0] cnt;
        dsd_sample_t conv;
        dsd_sample_t is_tap [7];
        dsd_sample_t is_y;
        dsd_sample_t g_q;
        dsd_sample_t dac_q;
        logic [3:0] res;
        wire logic wr_c = reg_wr && page[c]; // see R8
        wire dsd_factor_t fac = dsd_decode(interp_ratio_field); // see R5
        wire logic [1:0] k = dsd_stages(fac);
        wire logic bad = (fac == DSD_FBAD);
        wire logic [11:0] scaling_value = {scal_hi, scal_lo}; // see R13
        wire logic signed [15:0] whole_bias = {off_hi, off_lo}; // see R18
        wire dsd_sample_t hb_in [3];
        wire dsd_sample_t hb_out [3];
        wire dsd_sample_t chain;
        wire dsd_sample_t in_flip;
        wire logic signed [31:0] is_sum;
        wire dsd_sample_t is_val;
        wire logic signed [31:0] prod;
        wire logic signed [31:0] ofs_sum;

        always_ff @(posedge sys_clk) begin
            if (rst) begin
                fmt_sel <= 1'b0; // see R1
                rolloff_comp_on <= `DSD_R_ROLL; // see R10
                scaling_on <= `DSD_R_SCAL; // see R11
                interp_ratio_field <= `DSD_M_1X;
                bias_add_on <= 1'b0;
                off_lo <= 8'h00;
                off_hi <= 8'h00;
                fractional_bias <= 5'h00;
                scal_lo <= `DSD_R_GLO; // see R11
                scal_hi <= `DSD_R_GHI;
            end else if (wr_c) begin
                if (reg_addr == `DSD_A_FMT) begin
                    fmt_sel <= reg_wdata[`DSD_B_FMT];
                end
                if (reg_addr == `DSD_A_ENAB) begin
                    rolloff_comp_on <= reg_wdata[`DSD_B_INVS];
                    scaling_on <= reg_wdata[`DSD_B_GAIN];
                end
                if (reg_addr == `DSD_A_INTERP) begin
                    interp_ratio_field <= reg_wdata[2:0];
                end
                if (reg_addr == `DSD_A_OFFEN) begin
                    bias_add_on <= reg_wdata[`DSD_B_OFFEN];
                end
                if (reg_addr == `DSD_A_OFFLO) begin
                    off_lo <= reg_wdata;
                end
                if (reg_addr == `DSD_A_OFFHI) begin
                    off_hi <= reg_wdata;
                end
                if (reg_addr == `DSD_A_FRAC) begin
                    fractional_bias <= reg_wdata[4:0]; // see R19
                end
                if (reg_addr == `DSD_A_GLO) begin
                    scal_lo <= reg_wdata;
                end
                if (reg_addr == `DSD_A_GHI) begin
                    scal_hi <= reg_wdata[3:0];
                end
            end
        end

        // Readback of this channel's registers
        assign rb[c] =
            (reg_addr == `DSD_A_STATUS) ? 8'(8'(bad) << `DSD_B_BAD) : // see R6
            (reg_addr == `DSD_A_FMT) ? 8'(8'(fmt_sel) << `DSD_B_FMT) :
            (reg_addr == `DSD_A_ENAB) ? 8'((8'(rolloff_comp_on) << `DSD_B_INVS)
                | (8'(scaling_on) << `DSD_B_GAIN)) :
            (reg_addr == `DSD_A_INTERP) ? {5'h00, interp_ratio_field} :
            (reg_addr == `DSD_A_OFFEN) ? 8'(8'(bias_add_on) << `DSD_B_OFFEN) :
            (reg_addr == `DSD_A_OFFLO) ? off_lo :
            (reg_addr == `DSD_A_OFFHI) ? off_hi :
            (reg_addr == `DSD_A_FRAC) ? {3'h0, fractional_bias} :
            (reg_addr == `DSD_A_GLO) ? scal_lo :
            (reg_addr == `DSD_A_GHI) ? {4'h0, scal_hi} : 8'h00;

        // Input rate is the DAC rate over the factor; unsupported codes run 1x
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                cnt <= 3'h0;
            end else begin
                cnt <= cnt + 3'h1;
            end
        end
        assign take[c] = dsd_rate_en(cnt, k); // see R7

        // Offset binary differs from twos complement only in the sign bit
        assign in_flip = {~in_s[c][15], in_s[c][14:0]}; // see R2
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                conv <= 16'sh0000;
            end else if (take[c]) begin
                conv <= (fmt_sel ? in_flip : in_s[c]) & RES_MASK; // see R1 see R3
            end
        end

        // Half-band cascade, stage j runs at factor 2^(k-j) below DAC rate
        for (genvar j = 0; j < 3; j++) begin : hb_g
            wire logic [1:0] in_lg = (k > 2'(j)) ? 2'(k - 2'(j)) : 2'h0;
            wire logic [1:0] out_lg = (k > 2'(j)) ? 2'(k - 2'(j) - 2'h1) : 2'h0;
            if (j == 0) begin : first_g
                assign hb_in[j] = conv;
            end else begin : next_g
                assign hb_in[j] = hb_out[j-1];
            end
            dsd_halfband u_hb (
                .sys_clk(sys_clk),
                .rst(rst),
                .in_en(dsd_rate_en(cnt, in_lg)),
                .out_en(dsd_rate_en(cnt, out_lg)),
                .in_sample(hb_in[j]),
                .out_sample(hb_out[j])
            ); // see R4
        end
        assign chain = (k == 2'h0) ? conv : hb_out[2'(k - 2'h1)]; // see R21

        // Inverse sinc, symmetric seven taps at the DAC rate
        assign is_sum = `DSD_IS_C0 * (32'(is_tap[0]) + 32'(is_tap[6]))
            + `DSD_IS_C1 * (32'(is_tap[1]) + 32'(is_tap[5]))
            + `DSD_IS_C2 * (32'(is_tap[2]) + 32'(is_tap[4]))
            + `DSD_IS_C3 * 32'(is_tap[3]); // see R10
        assign is_val = dsd_sat16(is_sum >>> `DSD_IS_SHIFT);

        // Gain: a 13-bit positive multiplier keeps the product in 29 bits
        assign prod = 32'(is_y) * $signed({20'h0_0000, scaling_value}); // see R12 see R20
        // Offset in sixteenths, residue fed back so sub-LSB steps average out
        assign ofs_sum = (32'(g_q) <<< `DSD_FRAC_BITS)
            + (32'(whole_bias) <<< `DSD_FRAC_BITS)
            + 32'($signed(fractional_bias))
            + $signed({28'h000_0000, res}); // see R17

        always_ff @(posedge sys_clk) begin
            if (rst) begin
                for (int i = 0; i < 7; i++) begin
                    is_tap[i] <= 16'sh0000;
                end
                is_y <= 16'sh0000;
                g_q <= 16'sh0000;
                dac_q <= 16'sh0000;
                res <= 4'h0;
            end else begin
                is_tap[0] <= chain;
                for (int i = 1; i < 7; i++) begin
                    is_tap[i] <= is_tap[i-1];
                end
                is_y <= rolloff_comp_on ? is_val : chain; // see R21
                g_q <= scaling_on ? dsd_sat16(prod >>> `DSD_GAIN_SHIFT) : is_y; // see R22
                if (bias_add_on) begin
                    dac_q <= dsd_sat16(ofs_sum >>> `DSD_FRAC_BITS); // see R16 see R22
                    res <= ofs_sum[3:0];
                end else begin
                    dac_q <= g_q;
                end
            end
        end
    end

    assign dac0_code = ch_g[0].dac_q;
    assign dac1_code = ch_g[1].dac_q;

    // ************************************************************
    // Checks
    // ************************************************************
    a_page_reset: assert property (@(posedge sys_clk) // see R9
        rst |=> (page == `DSD_R_PAGE))
        else $error("page not both channels after reset");

    a_gain_default: assert property (@(posedge sys_clk) // see R11
        rst |=> (ch_g[1].scaling_on && ch_g[1].scaling_value == 12'hAEA))
        else $error("gain default wrong");

    a_invsinc_reset: assert property (@(posedge sys_clk) // see R10
        rst |=> ch_g[0].rolloff_comp_on)
        else $error("inverse sinc not enabled after reset");

    a_bad_mode_flag: assert property (@(posedge sys_clk) disable iff (rst) // see R6
        (reg_wr && reg_addr == `DSD_A_INTERP && page[0] && reg_wdata[2:0] == 3'h2)
        |=> ch_g[0].bad ##0 (rb[0] == 8'h01 || reg_addr != `DSD_A_STATUS))
        else $error("unsupported mode not flagged");

    // A mode write may end the 8x spacing early; only 8x cycles are judged
    a_take_8x: assert property (@(posedge sys_clk) disable iff (rst) // see R5
        (take[0] && ch_g[0].k == 2'h3)
        |=> (!take[0] || ch_g[0].k != 2'h3)[*7]
        ##1 (take[0] || ch_g[0].k != 2'h3))
        else $error("8x input spacing wrong");

    a_page_guard: assert property (@(posedge sys_clk) disable iff (rst) // see R8
        (reg_wr && page == 2'h2) |=> $stable(ch_g[0].scal_lo) && $stable(ch_g[0].fmt_sel))
        else $error("channel 0 written while paged out");

    a_fmt_flip: assert property (@(posedge sys_clk) disable iff (rst) // see R1
        (take[0] && ch_g[0].fmt_sel && !reg_wr)
        |=> (ch_g[0].conv[15] != $past(ch0_sample[15])))
        else $error("offset binary sign not inverted");

    a_gain_bypass: assert property (@(posedge sys_clk) disable iff (rst) // see R21
        (!ch_g[0].scaling_on && !reg_wr) |=> (ch_g[0].g_q == $past(ch_g[0].is_y)))
        else $error("disabled gain altered data");

    a_offset_off: assert property (@(posedge sys_clk) disable iff (rst) // see R16
        (!ch_g[1].bias_add_on && !reg_wr) |=> (dac1_code == $past(ch_g[1].g_q)))
        else $error("offset applied while disabled");

endmodule

`default_nettype wire

/* rtl/dsd_cfg.svh */
// Purpose: Named constants of the dual-channel DAC sample datapath.
// Assumes: Included by the package and by every design module.
// Notes: Register offsets are byte addresses of 8-bit registers.
`ifndef DSD_CFG_SVH
`define DSD_CFG_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define DSD_A_PAGE 12'h008
`define DSD_A_STATUS 12'h030
`define DSD_A_FMT 12'h110
`define DSD_A_ENAB 12'h111
`define DSD_A_INTERP 12'h112
`define DSD_A_OFFEN 12'h135
`define DSD_A_OFFLO 12'h136
`define DSD_A_OFFHI 12'h137
`define DSD_A_FRAC 12'h13A
`define DSD_A_GLO 12'h13C
`define DSD_A_GHI 12'h13D

// ************************************************************
// Field positions
// ************************************************************
`define DSD_B_FMT 7
`define DSD_B_INVS 7
`define DSD_B_GAIN 5
`define DSD_B_OFFEN 0
`define DSD_B_BAD 0

// ************************************************************
// Reset values
// ************************************************************
`define DSD_R_PAGE 2'h3
`define DSD_R_ROLL 1'b1
`define DSD_R_SCAL 1'b1
`define DSD_R_GLO 8'hEA
`define DSD_R_GHI 4'hA

// ************************************************************
// Interpolation mode codes
// ************************************************************
`define DSD_M_1X 3'h0
`define DSD_M_2X 3'h1
`define DSD_M_4X 3'h3
`define DSD_M_8X 3'h4

// ************************************************************
// Arithmetic
// ************************************************************
`define DSD_SMAX 32'sh0000_7FFF
`define DSD_SMIN 32'shFFFF_8000
`define DSD_GAIN_SHIFT 11
`define DSD_FRAC_BITS 4
`define DSD_HB_C 32'sh0000_0009
`define DSD_HB_SHIFT 4
`define DSD_IS_C0 32'shFFFF_FFFF
`define DSD_IS_C1 32'sh0000_0003
`define DSD_IS_C2 32'shFFFF_FFF4
`define DSD_IS_C3 32'sh0000_0114
`define DSD_IS_SHIFT 8
`define DSD_RES_BITS 16

`endif

/* rtl/dsd_pkg.sv */
// Purpose: Types and shared functions of the sample datapath.
// Assumes: dsd_cfg.svh provides the constants.
// Notes: Saturation is shared by every arithmetic stage.
`include "dsd_cfg.svh"

package dsd_pkg;

    typedef logic signed [15:0] dsd_sample_t;

    // Four-state base so the decoded factor can sit on a net
    typedef enum logic [2:0] {DSD_F1, DSD_F2, DSD_F4, DSD_F8, DSD_FBAD} dsd_factor_t;

    function automatic dsd_sample_t dsd_sat16(input logic signed [31:0] v);
        if (v > `DSD_SMAX) begin
            return 16'sh7FFF;
        end else if (v < `DSD_SMIN) begin
            return 16'sh8000;
        end
        return v[15:0];
    endfunction

    function automatic dsd_factor_t dsd_decode(input logic [2:0] m);
        case (m)
            `DSD_M_1X: return DSD_F1;
            `DSD_M_2X: return DSD_F2;
            `DSD_M_4X: return DSD_F4;
            `DSD_M_8X: return DSD_F8;
            default: return DSD_FBAD;
        endcase
    endfunction

    function automatic logic [1:0] dsd_stages(input dsd_factor_t f);
        case (f)
            DSD_F2: return 2'h1;
            DSD_F4: return 2'h2;
            DSD_F8: return 2'h3;
            default: return 2'h0;
        endcase
    endfunction

    function automatic logic dsd_rate_en(input logic [2:0] cnt, input logic [1:0] lg);
        logic [2:0] mask;
        mask = 3'((4'h1 << lg) - 4'h1);
        return (cnt & mask) == 3'h0;
    endfunction

endpackage

/* rtl/dsd_halfband.sv */
// Purpose: One 2x half-band interpolation stage.
// Assumes: in_en pulses only on cycles where out_en also pulses.
// Notes: Polyphase form, original samples pass through unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "dsd_cfg.svh"

module dsd_halfband import dsd_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Rate enables
    input wire logic in_en,
    input wire logic out_en,
    // Samples
    input wire dsd_sample_t in_sample,
    output dsd_sample_t out_sample
);

    dsd_sample_t tap [4];
    wire logic signed [31:0] mid_sum;
    wire dsd_sample_t mid_val;

    // ************************************************************
    // Midpoint between the two centre taps
    // ************************************************************
    assign mid_sum = `DSD_HB_C * (32'(tap[1]) + 32'(tap[2])) - 32'(tap[0]) - 32'(tap[3]);
    assign mid_val = dsd_sat16(mid_sum >>> `DSD_HB_SHIFT);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                tap[i] <= 16'sh0000;
            end
            out_sample <= 16'sh0000;
        end else begin
            if (in_en) begin
                tap[0] <= in_sample;
                for (int i = 1; i < 4; i++) begin
                    tap[i] <= tap[i-1];
                end
            end
            // Even phase passes an input sample, odd phase the midpoint
            if (out_en) begin
                out_sample <= in_en ? tap[1] : mid_val;
            end
        end
    end

endmodule

`default_nettype wire

/* tb/dsd_src.sv */
// Purpose: Sample source model for one channel of the datapath.
// Assumes: Bench hands in fresh words; take is the datapath strobe.
// Notes: Between takes the line toggles, so a stale word is never seen.
`timescale 1ns/1ps
`default_nettype none

module dsd_src import dsd_pkg::*; (
    // Clock
    input wire logic sys_clk,
    // Bench control
    input wire logic hold_on,
    input wire dsd_sample_t hold_val,
    input wire dsd_sample_t fresh,
    // Datapath side
    input wire logic take,
    output dsd_sample_t sample
);
    // ************************************************************
    // Source
    // ************************************************************
    initial sample = 16'h0000;
    // One word per take, at the take rate the datapath sets
    always @(negedge sys_clk) begin
        sample <= (take === 1'b1) ? (hold_on ? hold_val : fresh) : ~sample;
    end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Purpose: Self-checking bench of the dual-channel sample datapath.
// Assumes: Register strobes and latencies as handed over.
// Notes: Arithmetic compares allow one LSB, rounding is a design choice.
`timescale 1ns/1ps
`default_nettype none

module tb import dsd_pkg::*;;
    // ************************************************************
    // Signals and model state
    // ************************************************************
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    dsd_sample_t s0, s1, d0, d1;
    logic t0, t1;
    logic hold_on = 1'b0;
    dsd_sample_t hold_val = 16'h1234;
    logic [15:0] lfsr = 16'hC78B;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    logic stream_on = 1'b0;
    int exp0[int];
    int exp1[int];
    logic [1:0] page = 2'h3;
    int fmt[2] = '{0, 0};
    int gon[2] = '{1, 1};
    int oon[2] = '{0, 0};
    logic [15:0] offr[2] = '{16'h0000, 16'h0000};
    logic [11:0] gr[2] = '{12'hAEA, 12'hAEA};

    always #2.5 sys_clk = ~sys_clk;

    dsd_datapath dsd_datapath_i (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ch0_sample(s0), .ch1_sample(s1), .ch0_take(t0), .ch1_take(t1),
        .dac0_code(d0), .dac1_code(d1));
    dsd_src src0 (.sys_clk(sys_clk), .hold_on(hold_on), .hold_val(hold_val),
        .fresh(lfsr), .take(t0), .sample(s0));
    dsd_src src1 (.sys_clk(sys_clk), .hold_on(hold_on), .hold_val(hold_val),
        .fresh(~lfsr), .take(t1), .sample(s1));

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    function automatic int sat(input int v);
        return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
    endfunction

    // Format, gain, offset in order; disabled stages pass data untouched
    function automatic int model(input int ch, input logic [15:0] s);
        int v;
        v = fmt[ch] != 0 ? int'($signed(s ^ 16'h8000)) : int'($signed(s));
        if (gon[ch] != 0) begin
            v = sat((v * int'(gr[ch])) >>> 11);
        end
        if (oon[ch] != 0) begin
            v = sat(v + int'($signed(offr[ch])));
        end
        return v;
    endfunction

    task automatic chk(input logic [15:0] got, input int want, input int tol);
        int g;
        g = int'($signed(got));
        checked++;
        if (^got === 1'bx || g - want > tol || want - g > tol) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, want[15:0]);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ************************************************************
    // Register port
    // ************************************************************
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(negedge sys_clk);
        reg_wr <= 1'b0;
        if (a == 12'h008) begin
            page = d[1:0];
        end
        for (int c = 0; c < 2; c++) begin
            if (page[c] && a != 12'h008) begin
                case (a)
                    12'h110: fmt[c] = d[7];
                    12'h111: gon[c] = d[5];
                    12'h135: oon[c] = d[0];
                    12'h136: offr[c][7:0] = d;
                    12'h137: offr[c][15:8] = d;
                    12'h13C: gr[c][7:0] = d;
                    12'h13D: gr[c][11:8] = d[3:0];
                    default: ;
                endcase
            end
        end
        @(negedge sys_clk);
    endtask

    task automatic rd(input logic [11:0] a, output logic [7:0] q);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(negedge sys_clk);
        reg_rd <= 1'b0;
        q = reg_rdata;
        @(negedge sys_clk);
    endtask

    task automatic wait_take();
        int n;
        n = 0;
        while (t0 !== 1'b1) begin
            @(negedge sys_clk);
            n++;
            if (n > 16) begin
                n_errors++;
                $display("wrong value at %0t: got %h expected %h", $time, t0, 1'b1);
                stop_test();
            end
        end
    endtask

    // ************************************************************
    // Stream monitor
    // ************************************************************
    // Takes at edge k show on the codes after edge k+3
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (stream_on && t0 === 1'b1) begin
            exp0[cyc] = model(0, s0);
        end
        if (stream_on && t1 === 1'b1) begin
            exp1[cyc] = model(1, s1);
        end
    end

    always @(negedge sys_clk) begin
        lfsr <= lfsr_next(lfsr);
        if (stream_on && exp0.exists(cyc - 4)) begin
            chk(d0, exp0[cyc - 4], 1);
        end
        if (stream_on && exp1.exists(cyc - 4)) begin
            chk(d1, exp1[cyc - 4], 1);
        end
    end

    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        logic [7:0] q;
        int n;
        int sum;
        logic [11:0] ra[9] = '{12'h008, 12'h111, 12'h13C, 12'h13D, 12'h110, 12'h112,
            12'h030, 12'h135, 12'h200};
        int rv[9] = '{3, 160, 234, 10, 0, 0, 0, 0, 0};
        int fx[8] = '{1, 2, 1, 4, 8, 1, 1, 1};
        int bad[8] = '{0, 0, 1, 0, 0, 1, 1, 1};
        logic [7:0] dm[4][3] = '{'{8'h00, 8'hEA, 8'h0A}, '{8'h01, 8'hEA, 8'h0A},
            '{8'h03, 8'hB3, 8'h0B}, '{8'h04, 8'hF8, 8'h0B}};
        int fr[2] = '{8, -16};
        repeat (10) @(negedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        wr(12'h030, 8'hFF);
        for (int i = 0; i < 9; i++) begin
            rd(ra[i], q);
            chk({8'h00, q}, rv[i], 0);
        end
        $display("test reset_values done");
        for (int m = 0; m < 8; m++) begin
            wr(12'h112, m[7:0]);
            rd(12'h030, q);
            chk({15'h0000, q[0]}, bad[m], 0);
            n = 0;
            repeat (16) begin
                @(negedge sys_clk);
                n += int'(t0) + int'(t1);
            end
            chk(n[15:0], 32 / fx[m], 0);
        end
        $display("test interp_modes done");
        hold_on <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(12'h112, dm[i][0]);
            wr(12'h13C, dm[i][1]);
            wr(12'h13D, dm[i][2]);
            wait_take();
            repeat (60) @(negedge sys_clk);
            repeat (4) begin
                chk(d0, model(0, hold_val), 1);
                chk(d1, model(1, hold_val), 1);
                @(negedge sys_clk);
            end
        end
        $display("test dc_through_filters done");
        hold_on <= 1'b0;
        wr(12'h112, 8'h00);
        for (int i = 0; i < 4; i++) begin
            stream_on = 1'b0;
            for (int c = 1; c < 3; c++) begin
                wr(12'h008, c[7:0]);
                wr(12'h111, {2'h0, i[0], 5'h00});
                wr(12'h110, {i[1], 7'h00});
                wr(12'h13C, lfsr[7:0]);
                wr(12'h13D, {4'h0, lfsr[11:8]});
                wr(12'h135, {7'h00, lfsr[0]});
                wr(12'h136, lfsr[7:0]);
                wr(12'h137, lfsr[15:8]);
            end
            exp0.delete();
            exp1.delete();
            stream_on = 1'b1;
            repeat (150) @(negedge sys_clk);
        end
        stream_on = 1'b0;
        $display("test random_stream done");
        wr(12'h008, 8'h00);
        wr(12'h13C, 8'h55);
        for (int c = 0; c < 2; c++) begin
            wr(12'h008, c[7:0] + 8'h01);
            rd(12'h13C, q);
            chk({8'h00, q}, int'(gr[c][7:0]), 0);
        end
        $display("test paging done");
        hold_on <= 1'b1;
        hold_val <= 16'h0100;
        wr(12'h008, 8'h03);
        wr(12'h111, 8'h00);
        wr(12'h110, 8'h00);
        wr(12'h135, 8'h01);
        wr(12'h136, 8'h10);
        wr(12'h137, 8'h00);
        for (int k = 0; k < 2; k++) begin
            wr(12'h13A, {3'h0, fr[k][4:0]});
            repeat (20) @(negedge sys_clk);
            sum = 0;
            repeat (16) begin
                sum += int'($signed(d0));
                @(negedge sys_clk);
            end
            chk(sum[15:0], 16 * 272 + fr[k], 1);
        end
        $display("test sub_lsb_offset done");
        stop_test();
    end
endmodule
`default_nettype wire
